// *** core/dtt_pkg.sv ***
package dtt_pkg;
    // Clock and derived timing counts
    localparam int CLK_PS       = 25_000;
    localparam int TS_RES_PS    = 8_333;
    localparam int TS_STEP      = CLK_PS / TS_RES_PS;
    localparam int US_NS        = 1_000;
    localparam int US_CYC       = (US_NS * 1_000) / CLK_PS;
    localparam int MASK_FAST_US = 10;
    localparam int MASK_SLOW_US = 100;
    localparam int MASK_FAST    = MASK_FAST_US * US_CYC;
    localparam int MASK_SLOW    = MASK_SLOW_US * US_CYC;

    // Sizes
    localparam int TS_W         = 48;
    localparam int DEPTH        = 16;
    localparam int PTR_W        = 4;
    localparam int TGT_STAGES   = 8;
    localparam int NTRIG        = 2;

    // Register byte addresses
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_STAT    = 8'h04;
    localparam logic [7:0] A_TS_LO   = 8'h08;
    localparam logic [7:0] A_TS_HI   = 8'h0C;
    localparam logic [7:0] A_TIN     = 8'h10;
    localparam logic [7:0] A_TOUT    = 8'h14;
    localparam logic [7:0] A_TWIDTH  = 8'h18;
    localparam logic [7:0] A_IRQ_ST  = 8'h1C;
    localparam logic [7:0] A_IRQ_MSK = 8'h20;
    localparam logic [7:0] A_RD_IDX  = 8'h24;
    localparam logic [7:0] A_RD_DAT  = 8'h28;
    localparam logic [7:0] A_RD_TSL  = 8'h2C;
    localparam logic [7:0] A_RD_TSH  = 8'h30;

    // Control field positions
    localparam int C_RUN   = 0;
    localparam int C_SWTR  = 1;
    localparam int C_POL   = 2;
    localparam int C_SLOW  = 4;
    localparam int C_CONN  = 5;
    localparam int C_CORE  = 6;

    // Trigger input field layout, one byte per channel
    localparam int TI_LANE = 8;
    localparam int TI_ACT  = 3;
    localparam int TI_EN   = 4;

    // Interrupt bits
    localparam int IRQ_OVF  = 0;
    localparam int IRQ_FULL = 1;
    localparam int IRQ_BRK  = 2;
    localparam int IRQ_TRG0 = 3;
    localparam int IRQ_W    = 5;

    // Reset values
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] TIN_RST    = 32'h0000_0000;
    localparam logic [3:0]  TOUT_RST   = 4'h0;
    localparam logic [31:0] TWIDTH_RST = 32'h0001_0001;

    // Storage policies
    localparam logic [1:0] POL_RING  = 2'h0;
    localparam logic [1:0] POL_STOP  = 2'h1;
    localparam logic [1:0] POL_BREAK = 2'h2;

    // Trigger input detection modes
    localparam logic [2:0] TRG_RISE = 3'h0;
    localparam logic [2:0] TRG_FALL = 3'h1;
    localparam logic [2:0] TRG_BOTH = 3'h2;
    localparam logic [2:0] TRG_LOW  = 3'h3;
    localparam logic [2:0] TRG_HIGH = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STAMP,
        ST_RUN,
        ST_HALT
    } dtt_state_t;

    typedef struct packed {
        logic        ovf;
        logic [31:0] data;
    } dtt_rec_t;

    typedef struct packed {
        logic [TS_W-1:0] ts;
        dtt_rec_t        rec;
    } dtt_entry_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } dtt_wb_req_t;
endpackage : dtt_pkg

// *** core/dtt_unit.sv ***
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
// Contract
// [RL1] Each combined PC plus value trace entry takes one target buffer stage.
// [RL2] After seven filled stages the target stores an overflow marker in the eighth.
// [RL3] Every received record gets a timestamp of 8.333 ns resolution, 27 days range.
// [RL4] Timestamp marks arrival at the emulator, not target execution time.
// [RL5] Timestamp counter runs before target execution is allowed.
// [RL6] Recording starts with program run and ends on a break.
// [RL7] Storage policies: ring overwrite, stop when full, break when full.
// [RL8] Acquisition favours target speed; the link is never stalled.
// [RL9] One core traced per connection; changing core needs reconnection.
// [RL10] Two trigger input channels and two trigger output channels.
// [RL11] Trigger inputs detect rising, falling, both edges, low or high level.
// [RL12] Trigger input breaks under software trace, else breaks or stops recording.
// [RL13] Break detection pulses a trigger output, set polarity, 1 to 65535 us.
// [RL14] Without software trace, breaks masked 10 us after start, 100 us on slow oscillator.
// [RL15] While tracing or triggers active, block memory access, event edits, reads, status; code blocks only trace reads and A_TIN writes.
// [RL16] Received trace records are stored in emulator-side memory.
// [RL17] Target sends no trace records when no emulator is connected.
// [RL18] Output pulse width timed by 16-bit down-counter on a 1 us tick.
// [RL19] Trigger inputs pass a two-stage synchroniser before detection.
module dtt_unit (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone slave
    input  wire dtt_pkg::dtt_wb_req_t  wb_req_i,
    output logic                       wb_ack_o,
    output logic [31:0]                wb_dat_o,
    output logic                       irq_o,
    // Debug link receiver side
    input  wire logic                  rec_valid_i,
    input  wire dtt_pkg::dtt_rec_t     rec_i,
    input  wire logic                  tgt_push_i,
    input  wire logic                  tgt_brk_i,
    output logic                       run_o,
    output logic                       brk_req_o,
    output logic                       trc_stop_o,
    output logic                       link_conn_o,
    output logic [1:0]                 core_sel_o,
    output logic                       block_o,
    // External trigger pins
    input  wire logic [1:0]            trig_in_i,
    output logic [1:0]                 trig_out_o
);

    function automatic logic [31:0] sel_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : sel_merge

    function automatic logic trig_hit(input logic [2:0] mode,
                                      input logic       cur,
                                      input logic       prev);
        logic hit;
        hit = 1'b0;
        case (mode)
            dtt_pkg::TRG_RISE: hit = cur & ~prev;
            dtt_pkg::TRG_FALL: hit = ~cur & prev;
            dtt_pkg::TRG_BOTH: hit = cur ^ prev;
            dtt_pkg::TRG_LOW:  hit = ~cur;
            dtt_pkg::TRG_HIGH: hit = cur;
            default:           hit = 1'b0;
        endcase
        return hit;
    endfunction : trig_hit

    // Registers
    dtt_pkg::dtt_state_t            state_r;
    dtt_pkg::dtt_state_t            state_nxt;
    logic [31:0]                    ctrl_r;
    logic [31:0]                    tin_r;
    logic [3:0]                     tout_r;
    logic [31:0]                    twidth_r;
    logic [dtt_pkg::IRQ_W-1:0]      irq_st_r;
    logic [dtt_pkg::IRQ_W-1:0]      irq_msk_r;
    logic [dtt_pkg::PTR_W-1:0]      rd_idx_r;
    logic [dtt_pkg::TS_W-1:0]       ts_r;
    logic                           ts_run_r;
    dtt_pkg::dtt_entry_t            mem_r [dtt_pkg::DEPTH];
    logic [dtt_pkg::PTR_W-1:0]      wr_ptr_r;
    logic [dtt_pkg::PTR_W:0]        count_r;
    logic                           rec_stop_r;
    logic [3:0]                     stage_r;
    logic [11:0]                    mask_cnt_r;
    logic [5:0]                     us_cnt_r;
    logic                           us_tick_r;
    logic [1:0]                     sync1_r;
    logic [1:0]                     sync2_r;
    logic [1:0]                     prev_r;
    logic [15:0]                    pulse_cnt_r [2];
    logic                           conn_r;

    // Bus decode
    wire        wb_hit  = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
    wire        wb_wr   = wb_hit & wb_req_i.we;
    wire [7:0]  adr     = wb_req_i.adr;
    wire        wr_ctrl = wb_wr & (adr == dtt_pkg::A_CTRL);
    wire        wr_tin  = wb_wr & (adr == dtt_pkg::A_TIN);
    wire        wr_tout = wb_wr & (adr == dtt_pkg::A_TOUT);
    wire        wr_tw   = wb_wr & (adr == dtt_pkg::A_TWIDTH);
    wire        wr_ist  = wb_wr & (adr == dtt_pkg::A_IRQ_ST);
    wire        wr_imsk = wb_wr & (adr == dtt_pkg::A_IRQ_MSK);
    wire        wr_ridx = wb_wr & (adr == dtt_pkg::A_RD_IDX);
    wire [31:0] wdat    = sel_merge(32'h0000_0000, wb_req_i.dat, wb_req_i.sel);

    // Control fields
    wire       run_req  = ctrl_r[dtt_pkg::C_RUN];
    wire       sw_trace = ctrl_r[dtt_pkg::C_SWTR];
    wire [1:0] policy   = ctrl_r[dtt_pkg::C_POL +: 2];
    wire       slow_osc = ctrl_r[dtt_pkg::C_SLOW];
    wire       conn_req = ctrl_r[dtt_pkg::C_CONN];
    wire [1:0] core_req = ctrl_r[dtt_pkg::C_CORE +: 2];

    // Trigger detection [RL10] [RL11]
    wire [1:0] tin_en;
    wire [1:0] tin_stop;
    wire [1:0] tin_hit;
    for (genvar n = 0; n < dtt_pkg::NTRIG; n++) begin : g_tin
        assign tin_en[n]   = tin_r[n*dtt_pkg::TI_LANE + dtt_pkg::TI_EN];
        assign tin_stop[n] = tin_r[n*dtt_pkg::TI_LANE + dtt_pkg::TI_ACT];
        assign tin_hit[n]  = tin_en[n] & (state_r == dtt_pkg::ST_RUN)
                           & trig_hit(tin_r[n*dtt_pkg::TI_LANE +: 3], sync2_r[n], prev_r[n]);
    end
    // Software trace forces break action; otherwise per-channel choice [RL12]
    wire       trg_brk  = |(tin_hit & (~tin_stop | {2{sw_trace}}));
    wire       trg_stop = |(tin_hit & tin_stop) & ~sw_trace;

    // Storage state
    wire       full      = (count_r == (dtt_pkg::PTR_W+1)'(dtt_pkg::DEPTH));
    wire       recording = (state_r == dtt_pkg::ST_RUN) & ~rec_stop_r;    // [RL6]
    wire       ring      = (policy == dtt_pkg::POL_RING);
    wire       store     = recording & rec_valid_i & (ring | ~full);      // [RL7] [RL8]
    wire       full_hit  = recording & rec_valid_i & ~ring & full;
    wire       full_brk  = full_hit & (policy == dtt_pkg::POL_BREAK);

    // Break detection with start-up mask [RL14]
    wire       brk_det  = (state_r == dtt_pkg::ST_RUN) & tgt_brk_i
                        & (sw_trace | (mask_cnt_r == 12'h000));

    // Block when tracing or trigger functions in use [RL15]
    wire       busy     = (state_r != dtt_pkg::ST_IDLE)
                        & (sw_trace | (|tin_en) | tout_r[1] | tout_r[3]);

    // Run sequencing: stamp counter first, then release target [RL5] [RL6]
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            dtt_pkg::ST_IDLE:  if (run_req & conn_r) state_nxt = dtt_pkg::ST_STAMP;
            dtt_pkg::ST_STAMP: state_nxt = dtt_pkg::ST_RUN;
            dtt_pkg::ST_RUN: begin
                if (!run_req) begin
                    state_nxt = dtt_pkg::ST_IDLE;
                end else if (brk_det) begin
                    state_nxt = dtt_pkg::ST_HALT;
                end
            end
            dtt_pkg::ST_HALT:  if (!run_req) state_nxt = dtt_pkg::ST_IDLE;
            default:           state_nxt = dtt_pkg::ST_IDLE;
        endcase
    end

    // Interrupt events; set wins over a write-one clear
    wire [dtt_pkg::IRQ_W-1:0] irq_ev  = {tin_hit, brk_det, full_hit,
                                         rec_valid_i & rec_i.ovf & recording};
    wire [dtt_pkg::IRQ_W-1:0] irq_nxt = (irq_st_r & ~(wr_ist ? wdat[dtt_pkg::IRQ_W-1:0]
                                                             : '0)) | irq_ev;

    // Read selection
    dtt_pkg::dtt_entry_t      rd_ent;
    assign rd_ent = mem_r[rd_idx_r];
    wire [31:0] stat_w = {8'h00, wr_ptr_r, 3'h0, count_r, stage_r,
                          2'h0, busy, rec_stop_r, full, ts_run_r,
                          state_r == dtt_pkg::ST_HALT, state_r == dtt_pkg::ST_RUN};
    wire [31:0] rd_mux =
        (adr == dtt_pkg::A_CTRL)    ? ctrl_r :
        (adr == dtt_pkg::A_STAT)    ? stat_w :
        (adr == dtt_pkg::A_TS_LO)   ? ts_r[31:0] :
        (adr == dtt_pkg::A_TS_HI)   ? {16'h0000, ts_r[47:32]} :
        (adr == dtt_pkg::A_TIN)     ? tin_r :
        (adr == dtt_pkg::A_TOUT)    ? {28'h000_0000, tout_r} :
        (adr == dtt_pkg::A_TWIDTH)  ? twidth_r :
        (adr == dtt_pkg::A_IRQ_ST)  ? {27'h000_0000, irq_st_r} :
        (adr == dtt_pkg::A_IRQ_MSK) ? {27'h000_0000, irq_msk_r} :
        (adr == dtt_pkg::A_RD_IDX)  ? {28'h000_0000, rd_idx_r} :
        (busy)                      ? 32'h0000_0000 :           // [RL15]
        (adr == dtt_pkg::A_RD_DAT)  ? rd_ent.rec.data :
        (adr == dtt_pkg::A_RD_TSL)  ? rd_ent.ts[31:0] :
        (adr == dtt_pkg::A_RD_TSH)  ? {rd_ent.rec.ovf, 15'h0000, rd_ent.ts[47:32]} :
                                      32'h0000_0000;

    // Bus slave
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= wb_hit ? rd_mux : 32'h0000_0000;
        end
    end

    // Software registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r    <= dtt_pkg::CTRL_RST;
            tin_r     <= dtt_pkg::TIN_RST;
            tout_r    <= dtt_pkg::TOUT_RST;
            twidth_r  <= dtt_pkg::TWIDTH_RST;
            irq_st_r  <= '0;
            irq_msk_r <= '0;
            rd_idx_r  <= '0;
            irq_o     <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_r <= sel_merge(ctrl_r, wb_req_i.dat, wb_req_i.sel);
            if (wr_tin && !busy) tin_r <= sel_merge(tin_r, wb_req_i.dat, wb_req_i.sel); // [RL15]
            if (wr_tout) tout_r <= wdat[3:0];
            if (wr_tw) twidth_r <= sel_merge(twidth_r, wb_req_i.dat, wb_req_i.sel);
            if (wr_imsk) irq_msk_r <= wdat[dtt_pkg::IRQ_W-1:0];
            if (wr_ridx) rd_idx_r <= wdat[dtt_pkg::PTR_W-1:0];
            irq_st_r <= irq_nxt;
            irq_o    <= |(irq_nxt & irq_msk_r);
        end
    end

    // Connection and core selection, core latched only at connect [RL9]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conn_r      <= 1'b0;
            link_conn_o <= 1'b0;
            core_sel_o  <= 2'h0;
        end else begin
            conn_r      <= conn_req;
            link_conn_o <= conn_req;
            if (conn_req && !conn_r) core_sel_o <= core_req;             // [RL9]
        end
    end

    // Timestamp counter: advances by three 8.333 ns units per clock [RL3] [RL5]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ts_r     <= '0;
            ts_run_r <= 1'b0;
        end else if (state_r == dtt_pkg::ST_IDLE) begin
            ts_run_r <= 1'b0;
            if (state_nxt == dtt_pkg::ST_STAMP) ts_r <= '0;
        end else begin
            ts_run_r <= 1'b1;
            ts_r     <= ts_r + dtt_pkg::TS_W'(dtt_pkg::TS_STEP);         // [RL3]
        end
    end

    // Sequencer, target control and start-up mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r    <= dtt_pkg::ST_IDLE;
            run_o      <= 1'b0;
            brk_req_o  <= 1'b0;
            trc_stop_o <= 1'b0;
            block_o    <= 1'b0;
            mask_cnt_r <= 12'h000;
        end else begin
            state_r    <= state_nxt;
            run_o      <= (state_nxt == dtt_pkg::ST_RUN) & ts_run_r;     // [RL5]
            block_o    <= busy;                                          // [RL15]
            if (state_nxt != dtt_pkg::ST_RUN) begin
                brk_req_o <= 1'b0;
            end else if (trg_brk || full_brk) begin
                brk_req_o <= 1'b1;                                       // [RL12] [RL7]
            end
            if (state_r == dtt_pkg::ST_IDLE) begin
                trc_stop_o <= 1'b0;
            end else if (trg_stop) begin
                trc_stop_o <= 1'b1;                                      // [RL12]
            end
            if (state_r == dtt_pkg::ST_STAMP) begin
                mask_cnt_r <= slow_osc ? 12'(dtt_pkg::MASK_SLOW)
                                       : 12'(dtt_pkg::MASK_FAST);        // [RL14]
            end else if (mask_cnt_r != 12'h000) begin
                mask_cnt_r <= mask_cnt_r - 12'h001;
            end
        end
    end

    // Emulator-side storage, stamped at arrival [RL16] [RL4] [RL7]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_r   <= '0;
            count_r    <= '0;
            rec_stop_r <= 1'b0;
        end else if (state_r == dtt_pkg::ST_STAMP) begin
            wr_ptr_r   <= '0;
            count_r    <= '0;
            rec_stop_r <= 1'b0;
        end else begin
            if (store) begin
                mem_r[wr_ptr_r] <= '{ts: ts_r, rec: rec_i};              // [RL4] [RL16]
                wr_ptr_r        <= wr_ptr_r + 4'h1;                      // [RL7]
                if (!full) count_r <= count_r + 5'h01;
            end
            if (full_hit) rec_stop_r <= 1'b1;                            // [RL7]
        end
    end

    // Target buffer stage tracking, one stage per entry [RL1] [RL2]
    always_ff @(posedge clk_i) begin
        if (rst_i || state_r == dtt_pkg::ST_IDLE) begin
            stage_r <= 4'h0;
        end else if (tgt_push_i && !rec_valid_i
                     && stage_r != 4'(dtt_pkg::TGT_STAGES)) begin
            stage_r <= stage_r + 4'h1;                                   // [RL1]
        end else if (rec_valid_i && !tgt_push_i && stage_r != 4'h0) begin
            stage_r <= stage_r - 4'h1;
        end
    end

    // Trigger input synchroniser [RL19]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
            prev_r  <= 2'h0;
        end else begin
            sync1_r <= trig_in_i;                                        // [RL19]
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // One microsecond tick [RL18]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            us_cnt_r  <= 6'h00;
            us_tick_r <= 1'b0;
        end else if (brk_det || us_cnt_r == 6'(dtt_pkg::US_CYC - 1)) begin
            us_cnt_r  <= 6'h00;
            us_tick_r <= ~brk_det;
        end else begin
            us_cnt_r  <= us_cnt_r + 6'h01;
            us_tick_r <= 1'b0;
        end
    end

    // Trigger output pulses on break detection [RL13] [RL18]
    for (genvar n = 0; n < dtt_pkg::NTRIG; n++) begin : g_tout
        wire [15:0] width = twidth_r[16*n +: 16];
        wire        pol   = tout_r[2*n];
        wire        en    = tout_r[2*n+1];
        logic [15:0] cnt_nxt;
        always_comb begin
            cnt_nxt = pulse_cnt_r[n];
            if (brk_det && en) begin
                cnt_nxt = (width == 16'h0000) ? 16'h0001 : width;      // [RL13]
            end else if (us_tick_r && pulse_cnt_r[n] != 16'h0000) begin
                cnt_nxt = pulse_cnt_r[n] - 16'h0001;                   // [RL18]
            end
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pulse_cnt_r[n] <= 16'h0000;
                trig_out_o[n]  <= 1'b1;
            end else begin
                pulse_cnt_r[n] <= cnt_nxt;
                trig_out_o[n]  <= (cnt_nxt != 16'h0000) ? pol : ~pol;  // [RL13]
            end
        end
    end

endmodule : dtt_unit

// *** dv/dtt_tgt_model.sv ***
`timescale 1ns/10ps
module dtt_tgt_model (
    // Control from bench
    input  wire logic         clk_i,
    input  wire logic         conn_i,
    input  wire logic         emit_i,
    input  wire logic [31:0]  data_i,
    input  wire logic         halt_i,
    input  wire logic         slow_i,
    // Link side
    output dtt_pkg::dtt_rec_t rec_o,
    output logic              rec_valid_o,
    output logic              push_o,
    output logic              brk_o
);
    dtt_pkg::dtt_rec_t q[$];
    int gap = 0;
    assign brk_o = halt_i;
    initial {rec_o, rec_valid_o, push_o} = '0;
    always @(posedge clk_i) begin
        push_o <= 1'b0;
        rec_valid_o <= 1'b0;
        rec_o <= ~rec_o; // Idle line inverts its previous value on every cycle that pops no record
        if (q.size() == 0) gap = 0;
        if (emit_i && conn_i && q.size() < 8) begin
            q.push_back(q.size() == 7 ? 33'h1_0000_0000 : {1'b0, data_i});
            push_o <= 1'b1;
        end
        gap++;
        if (q.size() > 0 && gap > (slow_i ? 200 : 4)) begin
            rec_o <= q.pop_front();
            rec_valid_o <= 1'b1;
            gap = 0;
        end
    end
endmodule : dtt_tgt_model

// *** dv/dtt_unit_properties.sv ***
`timescale 1ns/10ps
module dtt_unit_properties (
    // Clock, reset and bus
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire dtt_pkg::dtt_wb_req_t wb_req_i,
    input wire logic                 wb_ack_o,
    input wire logic [31:0]          wb_dat_o,
    input wire logic                 irq_o,
    // Target side
    input wire logic                 run_o,
    input wire logic                 brk_req_o,
    input wire logic                 link_conn_o,
    input wire logic [1:0]           core_sel_o,
    input wire logic [1:0]           trig_out_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_timing: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_req_i.cyc && wb_req_i.stb))
        else $error("ack without request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    a_reset_idle: assert property ($fell(rst_i) |-> !run_o && !brk_req_o && !irq_o && trig_out_o == 2'h3)
        else $error("outputs not idle after reset");
    a_run_conn: assert property ($rose(run_o) |-> $past(link_conn_o, 3))
        else $error("run without connection");
    a_core_held: assert property (link_conn_o && $past(link_conn_o) |-> $stable(core_sel_o))
        else $error("core changed while connected");
    a_run_mask: assert property ($rose(run_o) |-> run_o [*8])
        else $error("run dropped inside mask");
endmodule : dtt_unit_properties
bind dtt_unit dtt_unit_properties u_dtt_unit_properties (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq_o(irq_o),
    .run_o(run_o), .brk_req_o(brk_req_o), .link_conn_o(link_conn_o),
    .core_sel_o(core_sel_o), .trig_out_o(trig_out_o));

// *** dv/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    logic clk_i = 0, rst_i = 1, emit = 0, halt = 0, slow = 0;
    logic ack, irq, run, brq, tstop, conn, blk, rv, push, brk;
    logic [1:0] core, tout, tin = 0;
    logic [2:0] m;
    logic [31:0] dat, edat = 0, q, ex [16];
    dtt_pkg::dtt_wb_req_t req = '0;
    dtt_pkg::dtt_rec_t rec;
    int bad_count = 0, n_compared = 0;
    initial forever #12.5 clk_i = ~clk_i;
    dtt_unit u_dtt_unit (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(ack),
        .wb_dat_o(dat), .irq_o(irq), .rec_valid_i(rv), .rec_i(rec), .tgt_push_i(push),
        .tgt_brk_i(brk), .run_o(run), .brk_req_o(brq), .trc_stop_o(tstop), .link_conn_o(conn),
        .core_sel_o(core), .block_o(blk), .trig_in_i(tin), .trig_out_o(tout));
    dtt_tgt_model u_dtt_tgt_model (.clk_i(clk_i), .conn_i(conn), .emit_i(emit), .data_i(edat),
        .halt_i(halt), .slow_i(slow), .rec_o(rec), .rec_valid_o(rv), .push_o(push), .brk_o(brk));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) bad_count++;
        if (g !== e) $display("unexpected %s exp %h saw %h", nm, e, g);
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_i);
    endtask : cyc
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, 4'hF, a, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = dat;
        req <= '0;
    endtask : wb
    task automatic rst;
        rst_i <= 1'b1;
        cyc(8);
        rst_i <= 1'b0;
    endtask : rst
    task automatic start(input logic [1:0] p, input logic s);
        wb(1'b1, dtt_pkg::A_CTRL, {26'h000_0000, 2'h2, p, s, 1'b0});
        wb(1'b1, dtt_pkg::A_CTRL, {26'h000_0000, 2'h2, p, s, 1'b1});
        cyc(4);
        chk("run", 32'h1, {31'h0, run});
    endtask : start
    task automatic send(input int c, input int gap, input logic [1:0] p);
        logic [31:0] d;
        for (int k = 0; k < c; k++) begin
            d = (k == 0) ? 32'hFFFF_FFFF : $urandom;
            if (p == dtt_pkg::POL_RING || k < dtt_pkg::DEPTH) ex[k % 16] = d;
            edat <= d;
            emit <= 1'b1;
            @(posedge clk_i);
            if (gap > 0) emit <= 1'b0;
            cyc(gap);
        end
        emit <= 1'b0;
    endtask : send
    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    initial begin
        void'($urandom(94));
        rst();
        wb(1'b0, dtt_pkg::A_TWIDTH, 32'h0000_0000);
        chk("twidth", dtt_pkg::TWIDTH_RST, q);
        wb(1'b0, 8'h3C, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, q);
        $display("test reset done");
        for (int p = 0; p < 3; p++) begin
            rst();
            start(p[1:0], 1'b0);
            wb(1'b0, dtt_pkg::A_TS_LO, 32'h0000_0000);
            ex[0] = q + 32'h0000_0009;
            wb(1'b0, dtt_pkg::A_TS_LO, 32'h0000_0000);
            chk("stamp", ex[0], q);
            send(17, 5, p[1:0]);
            cyc(10);
            wb(1'b0, dtt_pkg::A_STAT, 32'h0000_0000);
            chk("count", 32'h0000_0010, {27'h000_0000, q[16:12]});
            chk("full", {31'h0, p != 0}, {31'h0, q[4]});
            chk("brkreq", {31'h0, p == 2}, {31'h0, brq});
            wb(1'b1, dtt_pkg::A_CTRL, 32'h0000_0020);
            for (int s = 0; s < 16; s++) begin
                wb(1'b1, dtt_pkg::A_RD_IDX, 32'(s));
                wb(1'b0, dtt_pkg::A_RD_DAT, 32'h0000_0000);
                chk("slot", ex[s], q);
            end
            $display("test policy done");
        end
        rst();
        start(2'h0, 1'b0);
        slow <= 1'b1;
        send(9, 0, 2'h0);
        wb(1'b0, dtt_pkg::A_STAT, 32'h0000_0000);
        chk("stages", 32'h0000_0008, {28'h000_0000, q[11:8]});
        cyc(1700);
        wb(1'b1, dtt_pkg::A_CTRL, 32'h0000_00E0);
        wb(1'b1, dtt_pkg::A_RD_IDX, 32'h0000_0007);
        chk("core", 32'h0, {30'h0, core});
        wb(1'b0, dtt_pkg::A_RD_TSH, 32'h0000_0000);
        chk("marker", 32'h1, {31'h0, q[31]});
        wb(1'b1, dtt_pkg::A_IRQ_MSK, 32'h0000_0001);
        cyc(2);
        chk("irq", 32'h1, {31'h0, irq});
        wb(1'b1, dtt_pkg::A_IRQ_ST, 32'h0000_0001);
        cyc(2);
        chk("irqclr", 32'h0, {31'h0, irq});
        slow <= 1'b0;
        $display("test overflow done");
        rst();
        wb(1'b1, dtt_pkg::A_TOUT, 32'h0000_0003);
        wb(1'b1, dtt_pkg::A_TWIDTH, 32'h0001_0002);
        chk("idle", 32'h0000_0002, {30'h0, tout});
        start(2'h0, 1'b0);
        cyc(20);
        halt <= 1'b1;
        cyc(5);
        halt <= 1'b0;
        cyc(5);
        chk("masked", 32'h1, {31'h0, run});
        cyc(400);
        halt <= 1'b1;
        cyc(6);
        chk("stopped", 32'h0, {31'h0, run});
        chk("pulse", 32'h1, {31'h0, tout[0]});
        cyc(32);
        chk("pulse", 32'h1, {31'h0, tout[0]});
        cyc(50);
        chk("pulse", 32'h0, {31'h0, tout[0]});
        halt <= 1'b0;
        $display("test break done");
        for (int i = 0; i < 7; i++) begin
            m = (i > 4) ? dtt_pkg::TRG_HIGH : 3'(i);
            rst();
            tin <= {1'b0, m == dtt_pkg::TRG_FALL || m == dtt_pkg::TRG_LOW};
            wb(1'b1, dtt_pkg::A_TIN, {27'h000_0000, 1'b1, i > 4, m});
            start(2'h0, i == 6);
            tin[0] <= ~tin[0];
            cyc(8);
            chk("brq", {31'h0, i != 5}, {31'h0, brq});
            chk("tstop", {31'h0, i == 5}, {31'h0, tstop});
            chk("block", 32'h1, {31'h0, blk});
        end
        $display("test trigger done");
        final_report();
    end
    initial begin
        cyc(20000);
        bad_count++;
        final_report();
    end
endmodule : testbench
